// ### hw/shbp_dev.sv
// Operation
// [RULE1] Data moves sixteen bits over shared bus.
// [RULE2] Seven-bit address picks registers or FIFOs.
// [RULE3] Host marks reads with low read strobe.
// [RULE4] Host marks writes with low write strobe.
// [RULE5] Strobes count only while device is selected.
// [RULE6] Selected write strobe ends reduced power state.
// [RULE7] FIFO steering forces data FIFO access.
// [RULE8] One interrupt, configurable polarity, source, drive.
// [RULE9] Programmable interval holds interrupt deasserted.
// [RULE10] Internal paths are thirty-two bits wide.
// [RULE11] Separate byte order for FIFOs and registers.
// [RULE12] Host-issued programmed transfers only, like SRAM.
// [RULE13] MAC registers bridged over separate internal bus.
// [RULE14] Separate transmit and receive buses to host.
// [RULE15] MAC buffers hidden; receive data via FIFO.
// [RULE16] Capture write at strobe end; gated read drive.
// [RULE17] Two halves, lowest address bit, one word.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "shbp_params.svh"
module shbp_dev
   import shbp_pkg::*;
#(
   parameter int EV_W = 4
)(
   input  wire logic            clk,
   input  wire logic            rstn,
   shbp_if.dev                  bus,
   input  wire shbp_word_t      rx_data,
   input  wire logic            rx_valid,
   output logic                 rx_pop_q,
   output shbp_word_t           tx_data_q,
   output logic                 tx_valid_q,
   output logic [4:0]           csr_addr_q,
   output shbp_word_t           csr_wdata_q,
   output logic                 csr_wr_q,
   output logic                 csr_rd_q,
   input  wire shbp_word_t      csr_rdata,
   input  wire logic [EV_W-1:0] mac_event,
   output logic                 low_power_q
);
   localparam int SW = EV_W + 1;
   logic            rd_q, wr_q, rd_p_q, wr_p_q;
   logic [6:0]      addr_q, acc_addr_q;
   logic            fsel_q, acc_fsel_q;
   shbp_half_t      din_q, wcap_q, lo_q, dout_q;
   logic            dout_oe_n_q;
   shbp_word_t      snap_q, cfg_q, live, rsw, wsw;
   logic [1:0]      order_q;
   logic [SW-1:0]   sts_q, en_q;
   logic            irq_act_q, irq_out_q, irq_oe_n_q;
   logic [7:0]      deas_q;
   logic [15:0]     pre_q;
   logic            rd_fifo, rd_csr, acc_fifo, acc_csr, wr_end, rd_end;
   logic [5:0]      rd_ix, acc_ix;
   logic            pend, wake;

   // Strobes are qualified by the select before anything looks at them.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_q   <= 1'b0;
         wr_q   <= 1'b0;
         rd_p_q <= 1'b0;
         wr_p_q <= 1'b0;
         addr_q <= 7'h00;
         fsel_q <= 1'b0;
         din_q  <= 16'h0000;
      end else begin
         rd_q   <= !bus.device_select_low && !bus.read_strobe_low; // [RULE5] [RULE3]
         wr_q   <= !bus.device_select_low && !bus.write_strobe_low; // [RULE5] [RULE4]
         rd_p_q <= rd_q;
         wr_p_q <= wr_q;
         addr_q <= bus.addr; // [RULE2]
         fsel_q <= bus.fifo_sel;
         din_q  <= bus.data; // [RULE1]
      end
   end

   // The last sampled values of a strobe are the ones that count.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_addr_q <= 7'h00;
         acc_fsel_q <= 1'b0;
         wcap_q     <= 16'h0000;
      end else if (rd_q || wr_q) begin
         acc_addr_q <= addr_q;
         acc_fsel_q <= fsel_q;
         wcap_q     <= din_q; // [RULE16]
      end
   end

   assign wr_end   = wr_p_q && !wr_q;
   assign rd_end   = rd_p_q && !rd_q;
   assign wake     = wr_q && !wr_p_q && low_power_q;
   assign rd_ix    = fsel_q ? `SHBP_IX_FIFO : addr_q[6:1]; // [RULE7]
   assign acc_ix   = acc_fsel_q ? `SHBP_IX_FIFO : acc_addr_q[6:1]; // [RULE7]
   assign rd_fifo  = rd_ix == `SHBP_IX_FIFO;
   assign rd_csr   = rd_ix[`SHBP_IX_CSR];
   assign acc_fifo = acc_ix == `SHBP_IX_FIFO;
   assign acc_csr  = acc_ix[`SHBP_IX_CSR];

   // Receive data only ever comes from the receive FIFO port.
   always_comb begin
      live = 32'h00000000;
      if (rd_fifo) begin
         live = rx_valid ? rx_data : 32'h00000000; // [RULE15] [RULE14]
      end else if (rd_csr) begin
         live = csr_rdata; // [RULE13]
      end else begin
         unique case (rd_ix)
            `SHBP_IX_IRQCFG: live = cfg_q;
            `SHBP_IX_INTSTS: live = 32'(sts_q);
            `SHBP_IX_INTEN:  live = 32'(en_q);
            `SHBP_IX_ORDER:  live = 32'(order_q);
            `SHBP_IX_PWR:    live = {30'h00000000, irq_act_q, low_power_q};
            `SHBP_IX_TEST:   live = `SHBP_TEST_VAL;
            default:         live = 32'h00000000;
         endcase
      end
   end

   shbp_order u_rd_order (
      .big  (rd_fifo ? order_q[`SHBP_ORD_FIFO] : order_q[`SHBP_ORD_REG]),
      .din  (live),
      .dout (rsw)
   ); // [RULE11]

   shbp_order u_wr_order (
      .big  (acc_fifo ? order_q[`SHBP_ORD_FIFO] : order_q[`SHBP_ORD_REG]),
      .din  ({wcap_q, lo_q}),
      .dout (wsw)
   ); // [RULE11] [RULE17]

   // The lower half snapshots the whole word so both halves agree.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         snap_q      <= 32'h00000000;
         dout_q      <= 16'h0000;
         dout_oe_n_q <= 1'b1;
      end else begin
         dout_oe_n_q <= !rd_q; // [RULE16] [RULE1]
         if (rd_q && !addr_q[0]) begin
            snap_q <= rsw; // [RULE17] [RULE10]
            dout_q <= rsw[15:0];
         end else if (rd_q) begin
            dout_q <= snap_q[31:16]; // [RULE17]
         end
      end
   end

   // Only the upper half completes a read and pops the word.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_pop_q <= 1'b0;
         csr_rd_q <= 1'b0;
      end else begin
         rx_pop_q <= rd_end && acc_addr_q[0] && acc_fifo && rx_valid; // [RULE15]
         csr_rd_q <= rd_end && acc_addr_q[0] && !acc_fifo && acc_csr; // [RULE13]
      end
   end

   // Writes land only when the upper half ends, as one 32-bit word.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lo_q        <= 16'h0000;
         tx_data_q   <= 32'h00000000;
         tx_valid_q  <= 1'b0;
         csr_addr_q  <= 5'h00;
         csr_wdata_q <= 32'h00000000;
         csr_wr_q    <= 1'b0;
      end else begin
         tx_valid_q <= 1'b0;
         csr_wr_q   <= 1'b0;
         if (wr_end && !acc_addr_q[0]) begin
            lo_q <= wcap_q; // [RULE17]
         end else if (wr_end && acc_fifo) begin
            tx_data_q  <= wsw; // [RULE14] [RULE10]
            tx_valid_q <= 1'b1;
         end else if (wr_end && acc_csr) begin
            csr_addr_q  <= acc_ix[4:0]; // [RULE13]
            csr_wdata_q <= wsw;
            csr_wr_q    <= 1'b1;
         end else if (rd_q && rd_csr) begin
            // A read names its register early, so the data has settled
            // before the last snapshot of the lower half.
            csr_addr_q <= rd_ix[4:0]; // [RULE13]
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_q   <= 32'h00000000;
         order_q <= 2'b00;
         en_q    <= '0;
      end else if (wr_end && acc_addr_q[0] && !acc_fifo && !acc_csr) begin
         unique case (acc_ix)
            `SHBP_IX_IRQCFG: cfg_q <= wsw; // [RULE8] [RULE9]
            `SHBP_IX_ORDER:  order_q <= wsw[1:0]; // [RULE11]
            `SHBP_IX_INTEN:  en_q <= wsw[SW-1:0]; // [RULE8]
            default:         ;
         endcase
      end
   end

   // A write strobe that starts while asleep wakes the device at once.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_power_q <= 1'b0;
      end else if (wake) begin
         low_power_q <= 1'b0; // [RULE6]
      end else if (wr_end && acc_addr_q[0] && !acc_fifo && !acc_csr &&
                   acc_ix == `SHBP_IX_PWR) begin
         low_power_q <= wsw[`SHBP_PWR_LOW];
      end
   end

   // New events win over a write-one-to-clear in the same cycle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sts_q <= '0;
      end else if (wr_end && acc_addr_q[0] && !acc_fifo && !acc_csr &&
                   acc_ix == `SHBP_IX_INTSTS) begin
         sts_q <= (sts_q & ~wsw[SW-1:0]) | {wake, mac_event}; // [RULE8]
      end else begin
         sts_q <= sts_q | {wake, mac_event}; // [RULE8]
      end
   end

   assign pend = |(sts_q & en_q) && cfg_q[`SHBP_CFG_EN];

   // After the interrupt deasserts it stays inactive for the programmed interval,
   // which keeps a host from being re-interrupted during its handler exit.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_act_q <= 1'b0;
         deas_q    <= 8'h00;
         pre_q     <= 16'h0000;
      end else begin
         irq_act_q <= pend && deas_q == 8'h00; // [RULE9]
         if (irq_act_q && !pend) begin
            deas_q <= cfg_q[`SHBP_CFG_DEAS]; // [RULE9]
            pre_q  <= 16'(`SHBP_DEAS_CYC - 1);
         end else if (deas_q != 8'h00 && pre_q == 16'h0000) begin
            deas_q <= deas_q - 8'h01; // [RULE9]
            pre_q  <= 16'(`SHBP_DEAS_CYC - 1);
         end else if (deas_q != 8'h00) begin
            pre_q <= pre_q - 16'h0001;
         end
      end
   end

   // Open drain only pulls low, so the line can be wired with others.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_out_q  <= 1'b0;
         irq_oe_n_q <= 1'b1;
      end else if (cfg_q[`SHBP_CFG_PP]) begin
         irq_out_q  <= cfg_q[`SHBP_CFG_POL] ? irq_act_q : !irq_act_q; // [RULE8]
         irq_oe_n_q <= 1'b0;
      end else begin
         irq_out_q  <= 1'b0;
         irq_oe_n_q <= !irq_act_q; // [RULE8]
      end
   end

   assign bus.d_data      = dout_q;
   assign bus.d_data_oe_n = dout_oe_n_q;
   assign bus.irq_out     = irq_out_q;
   assign bus.irq_oe_n    = irq_oe_n_q;
endmodule
`default_nettype wire

// ### hw/shbp_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "shbp_params.svh"
module shbp_host
   import shbp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   shbp_if.host             bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire shbp_word_t  pwdata,
   output shbp_word_t       prdata_q,
   output logic             pready_q,
   output logic             pslverr_q,
   output logic             irq_q
);
   shbp_state_t st_q;
   shbp_word_t  cmd_q, wdata_q, rdata_q;
   logic [1:0]  sts_q, msk_q;
   logic        half_q, done, acc, wr_ok, hit;
   logic [3:0]  cnt_q;
   shbp_half_t  hd_q;
   logic        hoe_n_q, rd_n_q, wr_n_q, cs_n_q;

   assign acc   = psel && penable && pready_q;
   assign wr_ok = acc && pwrite;
   assign hit   = paddr == `SHBP_A_CMD || paddr == `SHBP_A_WDATA ||
                  paddr == `SHBP_A_RDATA || paddr == `SHBP_A_INTSTS ||
                  paddr == `SHBP_A_INTMSK;
   assign done  = st_q == st_gap && cnt_q == 4'h1 && half_q;

   // One wait state on every APB access.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else if (psel && penable && !pready_q) begin
         pready_q  <= 1'b1;
         pslverr_q <= !hit;
         unique case (paddr)
            `SHBP_A_CMD:    prdata_q <= {st_q != st_idle, cmd_q[30:0]};
            `SHBP_A_WDATA:  prdata_q <= wdata_q;
            `SHBP_A_RDATA:  prdata_q <= rdata_q;
            `SHBP_A_INTSTS: prdata_q <= {30'h00000000, sts_q};
            `SHBP_A_INTMSK: prdata_q <= {30'h00000000, msk_q};
            default:        prdata_q <= 32'h00000000;
         endcase
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_q   <= 32'h00000000;
         wdata_q <= 32'h00000000;
         msk_q   <= 2'b00;
      end else if (wr_ok) begin
         if (paddr == `SHBP_A_CMD && st_q == st_idle) cmd_q <= pwdata;
         if (paddr == `SHBP_A_WDATA) wdata_q <= pwdata;
         if (paddr == `SHBP_A_INTMSK) msk_q <= pwdata[1:0];
      end
   end

   // Completion and a live device interrupt win over a clear.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sts_q <= 2'b00;
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(sts_q & msk_q);
         sts_q <= (sts_q & ~((wr_ok && paddr == `SHBP_A_INTSTS) ?
                             pwdata[1:0] : 2'b00)) |
                  {bus.irq_line == cmd_q[`SHBP_CMD_ACTHI], done};
      end
   end

   // A word goes out as lower half, then upper half.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q    <= st_idle;
         half_q  <= 1'b0;
         cnt_q   <= 4'h0;
         hd_q    <= 16'h0000;
         hoe_n_q <= 1'b1;
         rd_n_q  <= 1'b1;
         wr_n_q  <= 1'b1;
         cs_n_q  <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         unique case (st_q)
            st_idle: if (wr_ok && paddr == `SHBP_A_CMD &&
                         pwdata[`SHBP_CMD_GO]) begin // [RULE12]
               st_q    <= st_setup;
               half_q  <= 1'b0;
               cs_n_q  <= 1'b0;
               hd_q    <= wdata_q[15:0];
               hoe_n_q <= !pwdata[`SHBP_CMD_WR]; // [RULE1]
            end
            st_setup: begin
               st_q   <= st_strobe;
               cnt_q  <= 4'(`SHBP_STB_CYC);
               rd_n_q <= cmd_q[`SHBP_CMD_WR]; // [RULE3]
               wr_n_q <= !cmd_q[`SHBP_CMD_WR]; // [RULE4]
            end
            st_strobe: if (cnt_q == 4'h1) begin
               st_q   <= st_gap;
               cnt_q  <= 4'(`SHBP_GAP_CYC);
               rd_n_q <= 1'b1;
               wr_n_q <= 1'b1;
               if (!cmd_q[`SHBP_CMD_WR] && half_q) rdata_q[31:16] <= bus.data;
               if (!cmd_q[`SHBP_CMD_WR] && !half_q) rdata_q[15:0] <= bus.data;
            end else begin
               cnt_q <= cnt_q - 4'h1;
            end
            st_gap: if (cnt_q == 4'h1 && !half_q) begin
               st_q   <= st_setup;
               half_q <= 1'b1; // [RULE17]
               hd_q   <= wdata_q[31:16];
            end else if (cnt_q == 4'h1) begin
               st_q    <= st_idle;
               cs_n_q  <= 1'b1;
               hoe_n_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 4'h1;
            end
         endcase
      end
   end

   assign bus.h_data            = hd_q;
   assign bus.h_data_oe_n       = hoe_n_q;
   assign bus.addr              = {cmd_q[6:1], half_q}; // [RULE2]
   assign bus.fifo_sel          = cmd_q[`SHBP_CMD_FSEL] && !cs_n_q; // [RULE7]
   assign bus.read_strobe_low   = rd_n_q;
   assign bus.write_strobe_low  = wr_n_q;
   assign bus.device_select_low = cs_n_q;
endmodule
`default_nettype wire

// ### hw/shbp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface shbp_if;
   logic [15:0] h_data;
   logic        h_data_oe_n;
   logic [15:0] d_data;
   logic        d_data_oe_n;
   logic [15:0] data;
   logic [6:0]  addr;
   logic        read_strobe_low;
   logic        write_strobe_low;
   logic        device_select_low;
   logic        fifo_sel;
   logic        irq_out;
   logic        irq_oe_n;
   logic        irq_line;
   // An undriven data bus floats high, as does the interrupt line.
   assign data = !d_data_oe_n ? d_data :
                 (!h_data_oe_n ? h_data : 16'hffff);
   assign irq_line = irq_oe_n ? 1'b1 : irq_out;
   modport dev (input data, addr, read_strobe_low, write_strobe_low,
                device_select_low, fifo_sel,
                output d_data, d_data_oe_n, irq_out, irq_oe_n);
   modport host (input data, irq_line,
                 output h_data, h_data_oe_n, addr, read_strobe_low,
                 write_strobe_low, device_select_low, fifo_sel);
endinterface
`default_nettype wire

// ### hw/shbp_order.sv
`timescale 1ns/10ps
`default_nettype none
module shbp_order
   import shbp_pkg::*;
(
   input  wire logic       big,
   input  wire shbp_word_t din,
   output var  shbp_word_t dout
);
   always_comb begin
      dout = big ? {din[7:0], din[15:8], din[23:16], din[31:24]} : din;
   end
endmodule
`default_nettype wire

// ### hw/shbp_params.svh
`ifndef SHBP_PARAMS_SVH
`define SHBP_PARAMS_SVH
`define SHBP_CLK_NS     25
`define SHBP_STB_NS     100
`define SHBP_STB_CYC    ((`SHBP_STB_NS + `SHBP_CLK_NS - 1) / `SHBP_CLK_NS)
`define SHBP_GAP_NS     50
`define SHBP_GAP_CYC    ((`SHBP_GAP_NS + `SHBP_CLK_NS - 1) / `SHBP_CLK_NS)
`define SHBP_DEAS_NS    10000
`define SHBP_DEAS_CYC   (`SHBP_DEAS_NS / `SHBP_CLK_NS)
`define SHBP_IX_FIFO    6'h00
`define SHBP_IX_IRQCFG  6'h14
`define SHBP_IX_INTSTS  6'h15
`define SHBP_IX_INTEN   6'h16
`define SHBP_IX_ORDER   6'h17
`define SHBP_IX_PWR     6'h18
`define SHBP_IX_TEST    6'h19
`define SHBP_IX_CSR     5
`define SHBP_TEST_VAL   32'h87654321
`define SHBP_CFG_EN     0
`define SHBP_CFG_POL    4
`define SHBP_CFG_PP     8
`define SHBP_CFG_DEAS   31:24
`define SHBP_ORD_FIFO   0
`define SHBP_ORD_REG    1
`define SHBP_PWR_LOW    0
`define SHBP_PWR_IRQ    1
`define SHBP_A_CMD      8'h00
`define SHBP_A_WDATA    8'h04
`define SHBP_A_RDATA    8'h08
`define SHBP_A_INTSTS   8'h0c
`define SHBP_A_INTMSK   8'h10
`define SHBP_CMD_ADDR   6:0
`define SHBP_CMD_WR     8
`define SHBP_CMD_FSEL   9
`define SHBP_CMD_ACTHI  12
`define SHBP_CMD_GO     31
`endif

// ### hw/shbp_pkg.sv
package shbp_pkg;
   typedef logic [15:0] shbp_half_t;
   typedef logic [31:0] shbp_word_t;
   typedef enum logic [1:0] {
      st_idle   = 2'b00,
      st_setup  = 2'b01,
      st_strobe = 2'b10,
      st_gap    = 2'b11
   } shbp_state_t;
endpackage

// ### verif/shbp_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
module shbp_link_chk (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [6:0] addr,
   input wire logic       read_strobe_low,
   input wire logic       write_strobe_low,
   input wire logic       device_select_low,
   input wire logic       fifo_sel,
   input wire logic       h_data_oe_n,
   input wire logic       d_data_oe_n
);
   logic rd_act;
   logic any_stb;
   assign rd_act  = !device_select_low && !read_strobe_low;
   assign any_stb = !read_strobe_low || !write_strobe_low;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_no_bus_fight: assert property (d_data_oe_n || h_data_oe_n)
      else $error("both ends drive the data bus");
   a_host_quiet_read: assert property (!read_strobe_low |-> h_data_oe_n)
      else $error("host drives data during a read");
   a_strobe_qualified: assert property (any_stb |-> !device_select_low)
      else $error("strobe without device select");
   a_one_strobe: assert property (read_strobe_low || write_strobe_low)
      else $error("read and write strobes together");
   a_wr_strobe_len: assert property ($fell(write_strobe_low) |->
      (!write_strobe_low)[*4] ##1 write_strobe_low)
      else $error("write strobe length wrong");
   a_rd_strobe_len: assert property ($fell(read_strobe_low) |->
      (!read_strobe_low)[*4] ##1 read_strobe_low)
      else $error("read strobe length wrong");
   a_addr_steady: assert property (any_stb && $past(any_stb) |->
      $stable(addr) && $stable(fifo_sel))
      else $error("address moved under a strobe");
   // Both halves of a command need a recovery gap before the next strobe.
   a_strobe_gap: assert property ($rose(any_stb == 1'b0) |->
      (read_strobe_low && write_strobe_low)[*3])
      else $error("strobe gap too short");
   a_read_drive: assert property (!d_data_oe_n |-> $past(rd_act, 1) ||
      $past(rd_act, 2) || $past(rd_act, 3))
      else $error("device drives data outside a read");
   a_sel_release: assert property ($rose(device_select_low) |->
      !$past(any_stb))
      else $error("select dropped under a strobe");
endmodule
`default_nettype wire

// ### verif/sram_like_host_bus_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "shbp_params.svh"
module sram_like_host_bus_port_bench
   import shbp_pkg::*;
;
   logic       clk, rstn, psel, penable, pwrite, rx_valid, acthi, e;
   logic       pready_q, pslverr_q, irq_q, rx_pop_q, tx_valid_q;
   logic       csr_wr_q, csr_rd_q, low_power_q;
   logic [7:0] paddr;
   logic [4:0] csr_addr_q;
   logic [3:0] mac_event;
   shbp_word_t pwdata, prdata_q, rx_data, csr_rdata, tx_data_q, csr_wdata_q;
   shbp_word_t tx_last, rd, t;
   int         n_mismatch, checked, tx_n, pop_n, cw_n, cr_n;
   shbp_if bus_if ();
   shbp_host u_shbp_host (.clk(clk), .rstn(rstn), .bus(bus_if), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .irq_q(irq_q));
   shbp_dev #(.EV_W(4)) u_shbp_dev (.clk(clk), .rstn(rstn), .bus(bus_if),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_pop_q(rx_pop_q),
      .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
      .csr_addr_q(csr_addr_q), .csr_wdata_q(csr_wdata_q),
      .csr_wr_q(csr_wr_q), .csr_rd_q(csr_rd_q), .csr_rdata(csr_rdata),
      .mac_event(mac_event), .low_power_q(low_power_q));
   shbp_link_chk u_shbp_link_chk (.clk(clk), .rstn(rstn), .addr(bus_if.addr),
      .read_strobe_low(bus_if.read_strobe_low),
      .write_strobe_low(bus_if.write_strobe_low),
      .device_select_low(bus_if.device_select_low),
      .fifo_sel(bus_if.fifo_sel), .h_data_oe_n(bus_if.h_data_oe_n),
      .d_data_oe_n(bus_if.d_data_oe_n));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Internal pulses last one cycle, so they are counted as they pass.
   always @(posedge clk) begin
      if (tx_valid_q === 1'b1) begin
         tx_n++;
         tx_last = tx_data_q;
      end
      if (rx_pop_q === 1'b1) pop_n++;
      if (csr_wr_q === 1'b1) cw_n++;
      if (csr_rd_q === 1'b1) cr_n++;
   end
   task automatic chk(input shbp_word_t got, input shbp_word_t exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input shbp_word_t wd, output shbp_word_t rdat,
                      output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      if (pready_q !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
      rdat = prdata_q;
      err  = pslverr_q;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // One pin command: load data, start, poll done, clear it, fetch result.
   task automatic cmd(input logic [6:0] a, input logic w, input logic fs,
                      input shbp_word_t wd);
      int n;
      n = 0;
      apb(1'b1, 8'h04, wd, t, e);
      apb(1'b1, 8'h00, {1'b1, 18'h0, acthi, 2'b0, fs, w, 1'b0, a}, t, e);
      do begin
         apb(1'b0, 8'h0c, 32'h0, t, e);
         n++;
      end while (t[0] !== 1'b1 && n < 40);
      if (t[0] !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
      apb(1'b1, 8'h0c, 32'h1, t, e);
      apb(1'b0, 8'h08, 32'h0, rd, e);
   endtask
   task automatic wait_for(input logic host_q, input logic v, input int lim);
      int   n;
      logic cur;
      n   = 0;
      cur = host_q ? irq_q : bus_if.irq_line;
      while (cur !== v && n < lim) begin
         @(posedge clk);
         n++;
         cur = host_q ? irq_q : bus_if.irq_line;
      end
      chk({31'h0, cur}, {31'h0, v});
      if (cur !== v) conclude();
   endtask
   task pulse_ev;
      @(posedge clk);
      mac_event <= 4'h1;
      @(posedge clk);
      mac_event <= 4'h0;
   endtask
   task t_regs;
      apb(1'b0, 8'h20, 32'h0, t, e);
      chk({31'h0, e}, 32'h1);
      cmd(7'h32, 1'b0, 1'b0, 32'h0);
      chk(rd, `SHBP_TEST_VAL);
      $display("regs test done");
   endtask
   task t_tx;
      cmd(7'h7c, 1'b1, 1'b1, 32'h11223344);
      chk(32'(tx_n), 32'h1);
      chk(tx_last, 32'h11223344);
      cmd(7'h2e, 1'b1, 1'b0, 32'h1);
      cmd(7'h00, 1'b1, 1'b0, 32'h11223344);
      chk(tx_last, 32'h44332211);
      cmd(7'h32, 1'b0, 1'b0, 32'h0);
      chk(rd, `SHBP_TEST_VAL);
      cmd(7'h2e, 1'b1, 1'b0, 32'h2);
      cmd(7'h32, 1'b0, 1'b0, 32'h0);
      chk(rd, 32'h21436587);
      cmd(7'h2e, 1'b1, 1'b0, 32'h0);
      $display("tx test done");
   endtask
   task t_rx;
      @(posedge clk);
      rx_data  <= 32'hcafe0123;
      rx_valid <= 1'b1;
      cmd(7'h7c, 1'b0, 1'b1, 32'h0);
      chk(rd, 32'hcafe0123);
      chk(32'(pop_n), 32'h1);
      rx_valid <= 1'b0;
      cmd(7'h00, 1'b0, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(32'(pop_n), 32'h1);
      $display("rx test done");
   endtask
   task t_csr;
      cmd(7'h46, 1'b1, 1'b0, 32'h0badf00d);
      chk(32'(cw_n), 32'h1);
      chk({27'h0, csr_addr_q}, 32'h3);
      chk(csr_wdata_q, 32'h0badf00d);
      cmd(7'h4a, 1'b0, 1'b0, 32'h0);
      chk(rd, 32'h5a5a1234);
      chk(32'(cr_n), 32'h1);
      chk({27'h0, csr_addr_q}, 32'h5);
      $display("csr test done");
   endtask
   task t_irq;
      int n;
      n     = 0;
      acthi = 1'b1;
      cmd(7'h28, 1'b1, 1'b0, 32'h01000111);
      cmd(7'h2c, 1'b1, 1'b0, 32'h1);
      // The released line looked active before setup, so drop that bit.
      apb(1'b1, 8'h0c, 32'h2, t, e);
      apb(1'b1, 8'h10, 32'h2, t, e);
      pulse_ev();
      wait_for(1'b0, 1'b1, 50);
      wait_for(1'b1, 1'b1, 20);
      apb(1'b1, 8'h10, 32'h0, t, e);
      wait_for(1'b1, 1'b0, 4);
      cmd(7'h2a, 1'b1, 1'b0, 32'h1);
      chk({31'h0, bus_if.irq_line}, 32'h0);
      pulse_ev();
      repeat (300) begin
         @(posedge clk);
         if (bus_if.irq_line !== 1'b0) n++;
      end
      chk(32'(n), 32'h0);
      wait_for(1'b0, 1'b1, 400);
      acthi = 1'b0;
      cmd(7'h28, 1'b1, 1'b0, 32'h01000001);
      chk({30'h0, bus_if.irq_line, bus_if.irq_oe_n}, 32'h0);
      cmd(7'h2a, 1'b1, 1'b0, 32'h1);
      chk({30'h0, bus_if.irq_line, bus_if.irq_oe_n}, 32'h3);
      $display("irq test done");
   endtask
   task t_pwr;
      cmd(7'h30, 1'b1, 1'b0, 32'h1);
      chk({31'h0, low_power_q}, 32'h1);
      cmd(7'h2c, 1'b1, 1'b0, 32'h1);
      chk({31'h0, low_power_q}, 32'h0);
      cmd(7'h2a, 1'b0, 1'b0, 32'h0);
      chk({31'h0, rd[4]}, 32'h1);
      $display("power test done");
   endtask
   initial begin
      rstn      = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      rx_data   = 32'h0;
      rx_valid  = 1'b0;
      csr_rdata = 32'h5a5a1234;
      mac_event = 4'h0;
      acthi     = 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_tx();
      t_rx();
      t_csr();
      t_irq();
      t_pwr();
      conclude();
   end
endmodule
`default_nettype wire
